// ==== rtl/cfg_field_reg.sv ====
`timescale 1ns/100ps
`default_nettype none

module cfg_field_reg #(
    parameter int W = 16,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // write port
    input wire logic we,
    input wire logic [W-1:0] wmask,
    input wire logic [W-1:0] wdata,
    // stored value
    output logic [W-1:0] q
);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= RST;
        end else if (we) begin
            q <= (q & ~wmask) | (wdata & wmask);
        end
    end

endmodule

`default_nettype wire

// ==== rtl/cfgcap_cfg.svh ====
`ifndef CFGCAP_CFG_SVH
`define CFGCAP_CFG_SVH

// register indices; byte address is four times the index
`define CFG_IDX_DEV_CAP2 10'h064
`define CFG_IDX_DEV_CTL2 10'h068
`define CFG_IDX_DEV_STS2 10'h06A
`define CFG_IDX_LINK_CAP2 10'h06C
`define CFG_IDX_LINK_CTL2 10'h070
`define CFG_IDX_LINK_STS2 10'h072
`define CFG_IDX_SLOT_CAP2 10'h074
`define CFG_IDX_SLOT_CTL2 10'h078
`define CFG_IDX_SLOT_STS2 10'h07A
`define CFG_IDX_RSVD_PRE_PM 10'h07C
`define CFG_IDX_RSVD_PRE_PM_END 10'h07F
`define CFG_IDX_PM_ID 10'h080
`define CFG_IDX_PM_NEXT 10'h081
`define CFG_IDX_PM_CAPS 10'h082
`define CFG_IDX_PM_CSR 10'h084
`define CFG_IDX_PM_BRIDGE 10'h086
`define CFG_IDX_PM_DATA 10'h087
`define CFG_IDX_RSVD_POST_PM 10'h088
`define CFG_IDX_RSVD_POST_PM_END 10'h08F
`define CFG_IDX_VEC_ID 10'h090
`define CFG_IDX_VEC_NEXT 10'h091
`define CFG_IDX_VEC_CTL 10'h092
`define CFG_IDX_VEC_TABLE 10'h094
`define CFG_IDX_VEC_PBA 10'h098
`define CFG_IDX_CAP_EN 10'h0C0

// fixed values
`define CFG_PM_ID_VAL 8'h01
`define CFG_VEC_ID_VAL 8'h11
`define CFG_PM_VERSION 3'h3
`define CFG_ZERO_WORD 32'h00000000

// writable masks and read masks
`define CFG_DEV_CTL2_WMASK 16'h87FF
`define CFG_LINK_CTL2_WMASK 16'hFFFF
`define CFG_VEC_CTL_WMASK 16'hC000
`define CFG_CAP_EN_WMASK 32'h00000001
`define CFG_LINK_CAP2_RMASK 32'h007FFFFE

// field positions
`define CFG_EQ_RESET_BIT 5
`define CFG_PM_NSR_BIT 3
`define CFG_PM_WEN_BIT 8
`define CFG_PM_WST_BIT 15
`define CFG_VEC_EN_BIT 15
`define CFG_VEC_MASK_BIT 14
`define CFG_CAP_EN_VEC_BIT 0

// power state codes
`define CFG_PWR_D0 2'h0
`define CFG_PWR_D1 2'h1
`define CFG_PWR_D2 2'h2
`define CFG_PWR_DEEPEST 2'h3

// reset values
`define CFG_DEV_CTL2_RST 16'h0000
`define CFG_LINK_CTL2_RST 16'h0001
`define CFG_VEC_CTL_RST 16'h0000
`define CFG_CAP_EN_RST 32'h00000001

`endif

// ==== rtl/cfgcap_pkg.sv ====
package cfgcap_pkg;

    typedef logic [9:0] reg_index_t;
    typedef logic [1:0] pwr_state_t;

    // equalization and de-emphasis state from the link
    typedef struct packed {
        logic reset_request;
        logic phase3_ok;
        logic phase2_ok;
        logic phase1_ok;
        logic complete;
        logic deemph_3p5db;
    } eq_status_s;

    // settings that software wrote, for user logic
    typedef struct packed {
        logic [15:0] device_control_second;
        logic [15:0] link_control_second;
        pwr_state_t power_state;
        logic wake_event_enable;
        logic wake_event_status;
        logic vector_enable;
        logic vector_function_mask;
        logic vector_present;
    } ctrl_out_s;

endpackage

// ==== rtl/config_space_capability_regs.sv ====
`include "cfgcap_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module config_space_capability_regs #(
    parameter int ADDR_W = 12,
    parameter logic CTO_DISABLE_SUPPORTED = 1'b1,
    parameter logic [3:0] CTO_RANGES = 4'hF,
    parameter logic [31:0] LINK_CAP2_VALUE = 32'h0000000E,
    parameter logic [7:0] PM_NEXT_PTR = 8'h90,
    parameter logic [4:0] PM_EVENT_SUPPORT = 5'h00,
    parameter logic PM_D2_SUPPORT = 1'b0,
    parameter logic PM_D1_SUPPORT = 1'b0,
    parameter logic [2:0] PM_AUX_CURRENT = 3'h0,
    parameter logic PM_DSI = 1'b0,
    parameter logic PM_CLOCK = 1'b0,
    parameter logic [7:0] PM_DATA_VALUE = 8'h00,
    parameter logic [7:0] VEC_NEXT_PTR = 8'hA0,
    parameter logic [10:0] VEC_TABLE_SIZE = 11'h000,
    parameter logic [28:0] VEC_TABLE_OFFSET = 29'h00000000,
    parameter logic [2:0] VEC_TABLE_REGION = 3'h0,
    parameter logic [28:0] PENDING_ARRAY_OFFSET = 29'h00000100,
    parameter logic [2:0] PENDING_ARRAY_REGION = 3'h0
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESETN,
    // register bus
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic PREADY,
    output logic [31:0] PRDATA,
    output logic PSLVERR,
    // link and wake events
    input wire cfgcap_pkg::eq_status_s LINK_EQ,
    input wire logic WAKE_EVENT,
    // settings for user logic
    output cfgcap_pkg::ctrl_out_s CTRL
);

    cfgcap_pkg::reg_index_t idx;
    logic aligned;
    logic wr;
    logic [31:0] lane;
    logic [15:0] dev_ctl2;
    logic [15:0] link_ctl2;
    logic [15:0] vec_ctl;
    logic [31:0] cap_en;
    logic vec_present;
    cfgcap_pkg::pwr_state_t power_state;
    cfgcap_pkg::pwr_state_t req_state;
    logic wake_en;
    logic wake_st;
    logic eq_req;
    logic [15:0] pm_caps;
    logic [15:0] pm_csr;
    logic [15:0] link_sts2;
    logic [31:0] dev_cap2;
    logic [31:0] next_rdata;
    logic next_err;

    assign idx = PADDR[ADDR_W-1:2];
    assign aligned = (PADDR[1:0] == 2'h0);
    assign lane = {{8{PSTRB[3]}}, {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}};
    // zero-wait slave: every access phase completes at once
    assign PREADY = 1'b1;
    assign wr = PSEL && PENABLE && PWRITE && PREADY && aligned;
    assign vec_present = cap_en[`CFG_CAP_EN_VEC_BIT];

    assign dev_cap2 = {27'h0000000, CTO_DISABLE_SUPPORTED, CTO_RANGES};

    assign pm_caps = {PM_EVENT_SUPPORT, PM_D2_SUPPORT, PM_D1_SUPPORT, PM_AUX_CURRENT,
                      PM_DSI, 1'b0, PM_CLOCK, `CFG_PM_VERSION};

    assign pm_csr = {wake_st, 6'h00, wake_en, 4'h0, 1'b1, 1'b0, power_state};

    assign link_sts2 = {10'h000, eq_req, LINK_EQ.phase3_ok, LINK_EQ.phase2_ok,
                        LINK_EQ.phase1_ok, LINK_EQ.complete, LINK_EQ.deemph_3p5db};

    // read-only bits masked off on write
    cfg_field_reg #(.W(16), .RST(`CFG_DEV_CTL2_RST)) u_dev_ctl2 (
        .clk(REF_CLK),
        .resetn(RESETN),
        .we(wr && idx == `CFG_IDX_DEV_CTL2),
        .wmask(`CFG_DEV_CTL2_WMASK & lane[15:0]),
        .wdata(PWDATA[15:0]),
        .q(dev_ctl2)
    );

    cfg_field_reg #(.W(16), .RST(`CFG_LINK_CTL2_RST)) u_link_ctl2 (
        .clk(REF_CLK),
        .resetn(RESETN),
        .we(wr && idx == `CFG_IDX_LINK_CTL2),
        .wmask(`CFG_LINK_CTL2_WMASK & lane[15:0]),
        .wdata(PWDATA[15:0]),
        .q(link_ctl2)
    );

    // only enable and function mask writable
    cfg_field_reg #(.W(16), .RST(`CFG_VEC_CTL_RST)) u_vec_ctl (
        .clk(REF_CLK),
        .resetn(RESETN),
        .we(wr && vec_present && idx == `CFG_IDX_VEC_CTL),
        .wmask(`CFG_VEC_CTL_WMASK & lane[15:0]),
        .wdata(PWDATA[15:0]),
        .q(vec_ctl)
    );

    cfg_field_reg #(.W(32), .RST(`CFG_CAP_EN_RST)) u_cap_en (
        .clk(REF_CLK),
        .resetn(RESETN),
        .we(wr && idx == `CFG_IDX_CAP_EN),
        .wmask(`CFG_CAP_EN_WMASK & lane),
        .wdata(PWDATA),
        .q(cap_en)
    );

    assign req_state = PWDATA[1:0];

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            power_state <= `CFG_PWR_D0;
        end else if (wr && idx == `CFG_IDX_PM_CSR && PSTRB[0]) begin
            case (req_state)
                `CFG_PWR_D1: begin
                    if (PM_D1_SUPPORT) begin
                        power_state <= req_state;
                    end
                end
                `CFG_PWR_D2: begin
                    if (PM_D2_SUPPORT) begin
                        power_state <= req_state;
                    end
                end
                default: begin
                    power_state <= req_state;
                end
            endcase
        end
    end

    // leaving the deepest state resets nothing here
    // enable only exists with event support
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            wake_en <= 1'b0;
        end else if (PM_EVENT_SUPPORT == 5'h00) begin
            wake_en <= 1'b0;
        end else if (wr && idx == `CFG_IDX_PM_CSR && PSTRB[1]) begin
            wake_en <= PWDATA[`CFG_PM_WEN_BIT];
        end
    end

    // status only with unpowered-state support; set wins over clear
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            wake_st <= 1'b0;
        end else if (!PM_EVENT_SUPPORT[4]) begin
            wake_st <= 1'b0;
        end else if (WAKE_EVENT) begin
            wake_st <= 1'b1;
        end else if (wr && idx == `CFG_IDX_PM_CSR && PSTRB[1] && PWDATA[`CFG_PM_WST_BIT]) begin
            wake_st <= 1'b0;
        end
    end

    // write one clears; a new request wins
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            eq_req <= 1'b0;
        end else if (LINK_EQ.reset_request) begin
            eq_req <= 1'b1;
        end else if (wr && idx == `CFG_IDX_LINK_STS2 && PSTRB[0]
                     && PWDATA[`CFG_EQ_RESET_BIT]) begin
            eq_req <= 1'b0;
        end
    end

    always_comb begin
        next_rdata = `CFG_ZERO_WORD;
        next_err = !aligned;
        case (idx) inside
            `CFG_IDX_DEV_CAP2: next_rdata = dev_cap2;
            `CFG_IDX_DEV_CTL2: next_rdata = {16'h0000, dev_ctl2};
            `CFG_IDX_LINK_CAP2: next_rdata = LINK_CAP2_VALUE & `CFG_LINK_CAP2_RMASK;
            `CFG_IDX_LINK_CTL2: next_rdata = {16'h0000, link_ctl2};
            `CFG_IDX_LINK_STS2: next_rdata = {16'h0000, link_sts2};
            `CFG_IDX_DEV_STS2, `CFG_IDX_SLOT_CAP2, `CFG_IDX_SLOT_CTL2, `CFG_IDX_SLOT_STS2,
            [`CFG_IDX_RSVD_PRE_PM:`CFG_IDX_RSVD_PRE_PM_END],
            [`CFG_IDX_RSVD_POST_PM:`CFG_IDX_RSVD_POST_PM_END]: next_rdata = `CFG_ZERO_WORD;
            `CFG_IDX_PM_ID: next_rdata = {24'h000000, `CFG_PM_ID_VAL};
            `CFG_IDX_PM_NEXT: next_rdata = {24'h000000, PM_NEXT_PTR};
            `CFG_IDX_PM_CAPS: next_rdata = {16'h0000, pm_caps};
            `CFG_IDX_PM_CSR: next_rdata = {16'h0000, pm_csr};
            `CFG_IDX_PM_BRIDGE: next_rdata = `CFG_ZERO_WORD;
            `CFG_IDX_PM_DATA: next_rdata = {24'h000000, PM_DATA_VALUE};
            `CFG_IDX_VEC_ID: next_rdata = {24'h000000, `CFG_VEC_ID_VAL};
            // rest of the vector capability hidden when absent
            `CFG_IDX_VEC_NEXT: begin
                next_rdata = vec_present ? {24'h000000, VEC_NEXT_PTR} : `CFG_ZERO_WORD;
            end
            // table size is vectors minus one
            `CFG_IDX_VEC_CTL: begin
                next_rdata = vec_present ? {16'h0000, vec_ctl[15:14], 3'h0, VEC_TABLE_SIZE}
                                         : `CFG_ZERO_WORD;
            end
            `CFG_IDX_VEC_TABLE: begin
                next_rdata = vec_present ? {VEC_TABLE_OFFSET, VEC_TABLE_REGION}
                                         : `CFG_ZERO_WORD;
            end
            // same layout for the pending array
            `CFG_IDX_VEC_PBA: begin
                next_rdata = vec_present ? {PENDING_ARRAY_OFFSET, PENDING_ARRAY_REGION}
                                         : `CFG_ZERO_WORD;
            end
            `CFG_IDX_CAP_EN: next_rdata = cap_en;
            default: next_err = 1'b1;
        endcase
    end

    // read data and error captured in the setup cycle, stand through the access
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            PRDATA <= `CFG_ZERO_WORD;
            PSLVERR <= 1'b0;
        end else if (PSEL && !PENABLE) begin
            PRDATA <= PWRITE ? `CFG_ZERO_WORD : next_rdata;
            PSLVERR <= next_err;
        end
    end

    // timeout disable passed to user logic
    // timeout value passed to user logic
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            CTRL <= '0;
        end else begin
            CTRL.device_control_second <= dev_ctl2;
            CTRL.link_control_second <= link_ctl2;
            CTRL.power_state <= power_state;
            CTRL.wake_event_enable <= wake_en;
            CTRL.wake_event_status <= wake_st;
            CTRL.vector_enable <= vec_present && vec_ctl[`CFG_VEC_EN_BIT];
            CTRL.vector_function_mask <= vec_present && vec_ctl[`CFG_VEC_MASK_BIT];
            CTRL.vector_present <= vec_present;
        end
    end

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESETN);

    sequence s_rd(logic [9:0] i);
        PSEL && !PENABLE && !PWRITE && idx == i && aligned;
    endsequence

    sequence s_wr(logic [9:0] i);
        wr && idx == i;
    endsequence

    a_rsvd_reads_zero: assert property (
        (s_rd(`CFG_IDX_DEV_STS2) or s_rd(`CFG_IDX_SLOT_CAP2) or s_rd(`CFG_IDX_RSVD_PRE_PM))
        |=> PRDATA == `CFG_ZERO_WORD)
        else $error("reserved word read nonzero");
    a_devcap_fixed: assert property (s_rd(`CFG_IDX_DEV_CAP2) |=>
        PRDATA[10:5] == 6'h00 && PRDATA[3:0] == CTO_RANGES)
        else $error("device capability value wrong");
    a_speed_written: assert property (s_wr(`CFG_IDX_LINK_CTL2) ##0 PSTRB[0] |=>
        link_ctl2[3:0] == $past(PWDATA[3:0])
        ##1 CTRL.link_control_second[3:0] == $past(PWDATA[3:0], 2))
        else $error("target speed not stored");
    a_eq_clear_w1c: assert property (s_wr(`CFG_IDX_LINK_STS2) ##0 (PSTRB[0] && PWDATA[5]
        && !LINK_EQ.reset_request) |=> !eq_req)
        else $error("equalization request not cleared");
    a_eq_reported: assert property (s_rd(`CFG_IDX_LINK_STS2) |=>
        PRDATA[4:0] == $past(LINK_EQ[4:0]) && PRDATA[15:6] == 10'h000)
        else $error("equalization status misreported");
    a_pm_id_fixed: assert property (s_rd(`CFG_IDX_PM_ID) |=> PRDATA == 32'h00000001)
        else $error("power identifier wrong");
    a_pm_version: assert property (s_rd(`CFG_IDX_PM_CAPS) |=>
        PRDATA[2:0] == 3'h3 && !PRDATA[4])
        else $error("power version wrong");
    a_pm_state_gate: assert property (s_wr(`CFG_IDX_PM_CSR) ##0 (PSTRB[0]
        && ((req_state == 2'h1 && !PM_D1_SUPPORT) || (req_state == 2'h2 && !PM_D2_SUPPORT)))
        |=> $stable(power_state))
        else $error("unsupported power state accepted");
    a_pm_state_d1: assert property (s_wr(`CFG_IDX_PM_CSR) ##0 (PSTRB[0] && PM_D1_SUPPORT
        && req_state == `CFG_PWR_D1) |=> power_state == `CFG_PWR_D1)
        else $error("supported power state refused");
    a_pm_state_take: assert property (s_wr(`CFG_IDX_PM_CSR) ##0 (PSTRB[0]
        && (req_state == 2'h0 || req_state == 2'h3)) |=> power_state == $past(req_state)
        ##1 CTRL.power_state == $past(req_state, 2))
        else $error("power state write lost");
    a_wake_status_zero: assert property (!PM_EVENT_SUPPORT[4] |-> !wake_st)
        else $error("wake status set without support");
    a_wake_status_set: assert property (WAKE_EVENT |=> wake_st == PM_EVENT_SUPPORT[4])
        else $error("wake event not recorded");
    a_wake_enable_zero: assert property (
        PM_EVENT_SUPPORT == 5'h00 |-> !CTRL.wake_event_enable)
        else $error("wake enable set without support");
    a_wake_enable_take: assert property (s_wr(`CFG_IDX_PM_CSR) ##0 PSTRB[1] |=>
        wake_en == ($past(PWDATA[`CFG_PM_WEN_BIT]) && PM_EVENT_SUPPORT != 5'h00))
        else $error("wake enable write lost");
    a_nsr_one: assert property (s_rd(`CFG_IDX_PM_CSR) |=>
        PRDATA[3] && PRDATA[7:4] == 4'h0)
        else $error("no soft reset bit not one");
    a_bridge_zero: assert property (s_rd(`CFG_IDX_PM_BRIDGE) |=>
        PRDATA == 32'h00000000)
        else $error("bridge byte nonzero");
    a_vec_absent_zero: assert property (!vec_present ##0 (s_rd(`CFG_IDX_VEC_CTL)
        or s_rd(`CFG_IDX_VEC_TABLE)) |=> PRDATA == 32'h00000000)
        else $error("absent vector capability not zero");
    a_vec_ctl_ro: assert property (vec_present ##0 s_rd(`CFG_IDX_VEC_CTL) |=>
        PRDATA[13:0] == {3'h0, VEC_TABLE_SIZE})
        else $error("vector control read-only bits changed");

endmodule

`default_nettype wire

// ==== verification/cfg_host.sv ====
`timescale 1ns/100ps
`default_nettype none

module cfg_host #(
    parameter int ADDR_W = 12
) (
    // clock
    input wire logic clk,
    // register bus
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = '0;
        pwdata = 32'h0;
        pstrb = 4'hF;
    end

    // one transfer: setup cycle, then access until pready is seen high
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // released lines do not keep the last value
        paddr <= ~addr;
        pwdata <= ~wd;
    endtask
endmodule

`default_nettype wire

// ==== verification/config_space_capability_regs_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cfgcap_cfg.svh"

module config_space_capability_regs_bench;
    localparam logic [9:0] RO_IDX [19] = '{`CFG_IDX_DEV_CAP2, `CFG_IDX_LINK_CAP2,
        `CFG_IDX_DEV_STS2, `CFG_IDX_SLOT_CAP2, `CFG_IDX_SLOT_CTL2, `CFG_IDX_SLOT_STS2,
        10'h07C, 10'h07F, `CFG_IDX_PM_ID, `CFG_IDX_PM_NEXT, `CFG_IDX_PM_CAPS,
        `CFG_IDX_PM_BRIDGE, `CFG_IDX_PM_DATA, 10'h088, 10'h08F, `CFG_IDX_VEC_ID,
        `CFG_IDX_VEC_NEXT, `CFG_IDX_VEC_TABLE, `CFG_IDX_VEC_PBA};
    localparam logic [31:0] RO_EXP [19] = '{32'h1F, 32'h0E, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h01, 32'h90, 32'h8203, 32'h0, 32'h0, 32'h0, 32'h0, 32'h11,
        32'hA0, 32'h205, 32'h800};
    localparam logic [1:0] PS_WR [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h2};
    localparam logic [1:0] PS_EXP [5] = '{2'h1, 2'h1, 2'h3, 2'h0, 2'h0};

    logic ref_clk = 1'h0;
    logic resetn = 1'h0;
    logic psel, penable, pwrite, pready, pslverr, wake_event, lerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] pstrb;
    cfgcap_pkg::eq_status_s link_eq;
    cfgcap_pkg::ctrl_out_s ctrl;
    int err_total = 0;
    int cmp_count = 0;

    always #4 ref_clk = ~ref_clk;

    config_space_capability_regs #(
        .PM_EVENT_SUPPORT(5'h10), .PM_D1_SUPPORT(1'h1), .VEC_TABLE_SIZE(11'h007),
        .VEC_TABLE_OFFSET(29'h40), .VEC_TABLE_REGION(3'h5)
    ) u_config_space_capability_regs (
        .REF_CLK(ref_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready),
        .PRDATA(prdata), .PSLVERR(pslverr), .LINK_EQ(link_eq), .WAKE_EVENT(wake_event),
        .CTRL(ctrl)
    );

    cfg_host u_cfg_host (
        .clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr)
    );

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
        u_cfg_host.xfer(1'h0, {idx, 2'h0}, 32'h0, rdat, lerr);
        chk($sformatf("reg %h", idx), exp, rdat);
        chk("slverr", 32'h0, 32'(lerr));
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
        u_cfg_host.xfer(1'h1, {idx, 2'h0}, wd, rdat, lerr);
    endtask

    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    task automatic finish_test();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge ref_clk);
        err_total++;
        finish_test();
    end

    initial begin
        link_eq <= 6'h1B;
        wake_event <= 1'h0;
        repeat (6) @(posedge ref_clk);
        resetn <= 1'h1;
        rd(`CFG_IDX_DEV_CTL2, 32'h0);
        rd(`CFG_IDX_LINK_CTL2, 32'h1);
        rd(`CFG_IDX_PM_CSR, 32'h8);
        // fixed words, then again after an all-ones overwrite
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 19; i++) begin
                rd(RO_IDX[i], RO_EXP[i]);
            end
            for (int i = 0; i < 19; i++) begin
                if (p == 0) wr(RO_IDX[i], 32'hFFFFFFFF);
            end
        end
        wr(`CFG_IDX_DEV_CTL2, 32'hFFFF);
        rd(`CFG_IDX_DEV_CTL2, 32'h87FF);
        settle();
        chk("ctrl dev_ctl2", 32'h87FF, 32'(ctrl.device_control_second));
        for (int s = 1; s < 4; s++) begin
            wr(`CFG_IDX_LINK_CTL2, 32'(s));
            rd(`CFG_IDX_LINK_CTL2, 32'(s));
            settle();
            chk("ctrl link_ctl2", 32'(s), 32'(ctrl.link_control_second));
        end
        // misaligned and unmapped accesses are refused
        u_cfg_host.xfer(1'h1, {`CFG_IDX_LINK_CTL2, 2'h1}, 32'h1, rdat, lerr);
        chk("slverr", 32'h1, 32'(lerr));
        u_cfg_host.xfer(1'h0, {10'h0A0, 2'h0}, 32'h0, rdat, lerr);
        chk("slverr", 32'h1, 32'(lerr));
        rd(`CFG_IDX_LINK_CTL2, 32'h3);
        @(posedge ref_clk);
        link_eq <= 6'h3B;
        @(posedge ref_clk);
        link_eq <= 6'h1B;
        rd(`CFG_IDX_LINK_STS2, 32'h3B);
        wr(`CFG_IDX_LINK_STS2, 32'hFFDF);
        rd(`CFG_IDX_LINK_STS2, 32'h3B);
        wr(`CFG_IDX_LINK_STS2, 32'h20);
        rd(`CFG_IDX_LINK_STS2, 32'h1B);
        link_eq <= 6'h15;
        rd(`CFG_IDX_LINK_STS2, 32'h15);
        link_eq <= 6'h0A;
        rd(`CFG_IDX_LINK_STS2, 32'h0A);
        for (int i = 0; i < 5; i++) begin
            wr(`CFG_IDX_PM_CSR, 32'(PS_WR[i]));
            rd(`CFG_IDX_PM_CSR, 32'h8 | 32'(PS_EXP[i]));
            settle();
            chk("ctrl power_state", 32'(PS_EXP[i]), 32'(ctrl.power_state));
        end
        rd(`CFG_IDX_LINK_CTL2, 32'h3);
        wr(`CFG_IDX_PM_CSR, 32'h0100);
        rd(`CFG_IDX_PM_CSR, 32'h0108);
        @(posedge ref_clk);
        wake_event <= 1'h1;
        @(posedge ref_clk);
        wake_event <= 1'h0;
        rd(`CFG_IDX_PM_CSR, 32'h8108);
        settle();
        chk("ctrl wake", 32'h3, 32'({ctrl.wake_event_enable, ctrl.wake_event_status}));
        wr(`CFG_IDX_PM_CSR, 32'h8100);
        rd(`CFG_IDX_PM_CSR, 32'h0108);
        settle();
        chk("ctrl wake", 32'h2, 32'({ctrl.wake_event_enable, ctrl.wake_event_status}));
        rd(`CFG_IDX_VEC_CTL, 32'h0007);
        wr(`CFG_IDX_VEC_CTL, 32'hFFFF);
        rd(`CFG_IDX_VEC_CTL, 32'hC007);
        settle();
        chk("ctrl vector", 32'h3, 32'({ctrl.vector_enable, ctrl.vector_function_mask}));
        chk("ctrl present", 32'h1, 32'(ctrl.vector_present));
        wr(`CFG_IDX_CAP_EN, 32'h0);
        rd(`CFG_IDX_VEC_ID, 32'h11);
        rd(`CFG_IDX_VEC_NEXT, 32'h0);
        rd(`CFG_IDX_VEC_CTL, 32'h0);
        rd(`CFG_IDX_VEC_TABLE, 32'h0);
        rd(`CFG_IDX_VEC_PBA, 32'h0);
        chk("ctrl present", 32'h0, 32'(ctrl.vector_present));
        chk("ctrl vector off", 32'h0, 32'({ctrl.vector_enable, ctrl.vector_function_mask}));
        wr(`CFG_IDX_CAP_EN, 32'h1);
        rd(`CFG_IDX_VEC_TABLE, 32'h205);
        rd(`CFG_IDX_VEC_PBA, 32'h800);
        finish_test();
    end
endmodule

`default_nettype wire
